// File: shared/flow_seq_pkg.sv
// ---------------------------------------------------------------
// Program-flow sequencer shared definitions
// ---------------------------------------------------------------
package flow_seq_pkg;

	// Instruction numbers handled here
	localparam logic [7:0] OP_JUMP_ALWAYS = 8'h16;
	localparam logic [7:0] OP_CALL_SUBROUTINE = 8'h17;
	localparam logic [7:0] OP_RETURN_SUBROUTINE = 8'h18;
	localparam logic [7:0] OP_WAIT = 8'h1B;

	// Wait condition types
	localparam logic [7:0] WAIT_TICKS = 8'h00;
	localparam logic [7:0] WAIT_TARGET_REACHED = 8'h01;
	localparam logic [7:0] HOME_SWITCH_WAIT = 8'h02;
	localparam logic [7:0] END_SWITCH_WAIT = 8'h03;
	localparam logic [7:0] HOMING_DONE_WAIT = 8'h04;

	// Value that selects the accumulator as tick count
	localparam logic [31:0] TICKS_FROM_ACC = 32'hFFFF_FFFF;

	// Condition code of the conditional jump that tests the timeout flag
	localparam logic [7:0] COND_TIMEOUT_ERROR = 8'h08;

	// Return stack
	localparam int STACK_DEPTH = 8;
	localparam logic [3:0] STACK_FULL = 4'h8;
	localparam logic [3:0] STACK_EMPTY = 4'h0;

	// Motors served
	localparam int NUM_MOTORS = 3;

	// Tick timing: 10 ms at a 50 MHz clock
	localparam int TICK_MS = 10;
	localparam int CLK_KHZ = 50000;
	localparam int TICK_CYCLES_DEF = TICK_MS * CLK_KHZ;

	// PC reset value and step
	localparam logic [31:0] PC_RESET = 32'h0000_0000;
	localparam logic [31:0] PC_STEP = 32'h0000_0001;

	// One stored instruction
	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] itype;
		logic [7:0] motor;
		logic [31:0] value;
	} instr_t;

	// Per-motor event levels
	typedef struct packed {
		logic [NUM_MOTORS-1:0] pos_reached;
		logic [NUM_MOTORS-1:0] home_switch;
		logic [NUM_MOTORS-1:0] end_switch;
		logic [NUM_MOTORS-1:0] homing_done;
	} motor_status_t;

endpackage : flow_seq_pkg

// File: src/program_flow_sequencer.sv
`timescale 1ns/1ps

// Functional notes
// - Jump always loads value field into PC
// - Call pushes PC plus one, then jumps to value
// - Return stack holds eight entries maximum
// - Call on full stack has no effect
// - Return pops last saved entry into PC
// - Return on empty stack is ignored
// - Flow instructions act only in standalone mode
// - Wait type 0 waits value ticks
// - PC stays on wait while pending
// - Wait type 1 waits target reached
// - Wait type 2 waits home switch
// - Wait type 3 waits end switch
// - Wait type 4 waits homing done
// - Event wait timeout; zero disables it
// - Value minus one uses accumulator count
// - Timeout sets sticky flag, cleared by instruction
// - One tick is ten milliseconds
// - Condition code 8 tests timeout flag
module program_flow_sequencer #(
	parameter int TICK_CYCLES = flow_seq_pkg::TICK_CYCLES_DEF
) (
	input wire logic core_clk_in,
	input wire logic srst_in,
	input wire logic standalone_in,
	input wire logic instr_valid_in,
	input wire flow_seq_pkg::instr_t instr_in,
	input wire logic [31:0] pc_in,
	input wire logic [31:0] accumulator_in,
	input wire flow_seq_pkg::motor_status_t motor_status_in,
	input wire logic clear_error_in,
	input wire logic [7:0] cond_type_in,
	output logic ready_out,
	output logic done_out,
	output logic [31:0] pc_out,
	output logic waiting_out,
	output logic timeout_error_flag_out,
	output logic flag_cond_met_out
);
	import flow_seq_pkg::*;

	typedef enum logic { ST_IDLE, ST_WAIT } state_t;

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	state_t state_ff, nxt_state;
	logic [31:0] stack_ff [STACK_DEPTH];
	logic [3:0] depth_ff, nxt_depth;
	logic [31:0] pc_ff, nxt_pc;
	logic done_ff, nxt_done;
	logic flag_ff, nxt_flag;
	logic [31:0] ticks_ff, nxt_ticks;
	logic [31:0] presc_ff, nxt_presc;
	logic [7:0] wtype_ff, nxt_wtype;
	logic [7:0] wmotor_ff, nxt_wmotor;
	logic tmo_en_ff, nxt_tmo_en;

	// ---------------------------------------------------------------
	// Decode
	// ---------------------------------------------------------------
	wire accept = instr_valid_in && ready_out;
	wire active = accept && standalone_in;
	wire is_jump = active && instr_in.opcode == OP_JUMP_ALWAYS;
	wire is_call = active && instr_in.opcode == OP_CALL_SUBROUTINE;
	wire is_ret = active && instr_in.opcode == OP_RETURN_SUBROUTINE;
	wire is_wait = active && instr_in.opcode == OP_WAIT;
	wire stack_full = depth_ff == STACK_FULL;
	wire stack_empty = depth_ff == STACK_EMPTY;
	wire [31:0] pc_seq = pc_in + PC_STEP;
	wire [2:0] top_idx = 3'(depth_ff - 4'h1);
	wire [31:0] top_entry = stack_ff[top_idx];
	wire do_push = is_call && !stack_full;
	wire do_pop = is_ret && !stack_empty;

	// Tick count source: literal or accumulator
	wire [31:0] wait_amount = (instr_in.value == TICKS_FROM_ACC) ?
		accumulator_in : instr_in.value;

	// ---------------------------------------------------------------
	// Wait condition evaluation
	// ---------------------------------------------------------------
	wire motor_ok = wmotor_ff < 8'(NUM_MOTORS);
	wire [1:0] midx = wmotor_ff[1:0];
	wire ev_pos = motor_ok && motor_status_in.pos_reached[midx];
	wire ev_home = motor_ok && motor_status_in.home_switch[midx];
	wire ev_end = motor_ok && motor_status_in.end_switch[midx];
	wire ev_hdone = motor_ok && motor_status_in.homing_done[midx];
	wire is_event_type = wtype_ff == WAIT_TARGET_REACHED ||
		wtype_ff == HOME_SWITCH_WAIT || wtype_ff == END_SWITCH_WAIT ||
		wtype_ff == HOMING_DONE_WAIT;
	wire event_hit = (wtype_ff == WAIT_TARGET_REACHED && ev_pos) ||
		(wtype_ff == HOME_SWITCH_WAIT && ev_home) ||
		(wtype_ff == END_SWITCH_WAIT && ev_end) ||
		(wtype_ff == HOMING_DONE_WAIT && ev_hdone);

	// Tick prescaler; one pulse every tick period
	wire tick_pulse = presc_ff == 32'(TICK_CYCLES - 1);
	wire count_on = (wtype_ff == WAIT_TICKS) || tmo_en_ff;
	wire count_out = (ticks_ff == 32'h0000_0000) ||
		(tick_pulse && ticks_ff == 32'h0000_0001);
	wire in_wait = state_ff == ST_WAIT;
	wire tick_done = in_wait && wtype_ff == WAIT_TICKS && count_out;
	wire cond_done = in_wait && is_event_type && event_hit;
	wire tmo_expire = in_wait && is_event_type && !event_hit &&
		tmo_en_ff && count_out;
	wire bad_type = in_wait && !is_event_type && wtype_ff != WAIT_TICKS;
	wire wait_end = tick_done || cond_done || tmo_expire || bad_type;

	// Handshake and status outputs
	assign ready_out = state_ff == ST_IDLE;
	assign waiting_out = in_wait;
	assign done_out = done_ff;
	assign pc_out = pc_ff;
	assign timeout_error_flag_out = flag_ff;
	assign flag_cond_met_out = (cond_type_in == COND_TIMEOUT_ERROR) &&
		flag_ff;

	// ---------------------------------------------------------------
	// Next-state logic
	// ---------------------------------------------------------------
	always_comb
	begin
		nxt_state = state_ff;
		nxt_depth = depth_ff;
		nxt_pc = pc_ff;
		nxt_done = 1'b0;
		nxt_ticks = ticks_ff;
		nxt_presc = presc_ff;
		nxt_wtype = wtype_ff;
		nxt_wmotor = wmotor_ff;
		nxt_tmo_en = tmo_en_ff;
		// Timeout flag: set wins over clear
		nxt_flag = (flag_ff && !clear_error_in) || tmo_expire;
		unique case (state_ff)
			ST_WAIT:
			begin
				if (wait_end)
				begin
					nxt_state = ST_IDLE;
					nxt_done = 1'b1;
					nxt_pc = pc_ff + PC_STEP;
				end
				else if (count_on)
				begin
					nxt_presc = tick_pulse ? 32'h0000_0000 :
						presc_ff + 32'h0000_0001;
					if (tick_pulse)
						nxt_ticks = ticks_ff - 32'h0000_0001;
				end
			end
			ST_IDLE:
			begin
				if (accept)
				begin
					nxt_done = 1'b1;
					nxt_pc = pc_seq;
					if (is_jump)
						nxt_pc = instr_in.value;
					if (do_push)
					begin
						nxt_pc = instr_in.value;
						nxt_depth = depth_ff + 4'h1;
					end
					if (do_pop)
					begin
						nxt_pc = top_entry;
						nxt_depth = depth_ff - 4'h1;
					end
					if (is_wait)
					begin
						// Hold PC on the wait and load the counter
						nxt_done = 1'b0;
						nxt_pc = pc_in;
						nxt_state = ST_WAIT;
						nxt_ticks = wait_amount;
						nxt_presc = 32'h0000_0000;
						nxt_wtype = instr_in.itype;
						nxt_wmotor = instr_in.motor;
						nxt_tmo_en = wait_amount != 32'h0000_0000;
					end
				end
			end
		endcase
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	// Control state with reset
	always_ff @(posedge core_clk_in)
	begin
		if (srst_in)
		begin
			state_ff <= ST_IDLE;
			depth_ff <= STACK_EMPTY;
			pc_ff <= PC_RESET;
			done_ff <= 1'b0;
			flag_ff <= 1'b0;
			ticks_ff <= 32'h0000_0000;
			presc_ff <= 32'h0000_0000;
			wtype_ff <= 8'h00;
			wmotor_ff <= 8'h00;
			tmo_en_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			depth_ff <= nxt_depth;
			pc_ff <= nxt_pc;
			done_ff <= nxt_done;
			flag_ff <= nxt_flag;
			ticks_ff <= nxt_ticks;
			presc_ff <= nxt_presc;
			wtype_ff <= nxt_wtype;
			wmotor_ff <= nxt_wmotor;
			tmo_en_ff <= nxt_tmo_en;
		end
	end

	// Return address storage; depth guards validity
	always_ff @(posedge core_clk_in)
	begin
		if (do_push)
			stack_ff[depth_ff[2:0]] <= pc_seq;
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	a_jump_target: assert property (@(posedge core_clk_in)
		disable iff (srst_in)
		is_jump |=> done_ff && pc_ff == $past(instr_in.value))
		else $error("jump did not load target");

	a_call_push: assert property (@(posedge core_clk_in)
		disable iff (srst_in)
		do_push |=> depth_ff == $past(depth_ff) + 4'h1 &&
			pc_ff == $past(instr_in.value))
		else $error("call did not push and jump");

	a_stack_bound: assert property (@(posedge core_clk_in)
		disable iff (srst_in)
		depth_ff <= STACK_FULL)
		else $error("return stack deeper than eight");

	a_call_full: assert property (@(posedge core_clk_in)
		disable iff (srst_in)
		is_call && stack_full |=> depth_ff == STACK_FULL &&
			pc_ff == $past(pc_seq))
		else $error("call on full stack took effect");

	a_return_pop: assert property (@(posedge core_clk_in)
		disable iff (srst_in)
		do_pop |=> pc_ff == $past(top_entry) &&
			depth_ff == $past(depth_ff) - 4'h1)
		else $error("return did not pop");

	a_return_empty: assert property (@(posedge core_clk_in)
		disable iff (srst_in)
		is_ret && stack_empty |=> depth_ff == STACK_EMPTY &&
			pc_ff == $past(pc_seq))
		else $error("return on empty stack took effect");

	a_direct_ignored: assert property (@(posedge core_clk_in)
		disable iff (srst_in)
		accept && !standalone_in |=> done_ff && !in_wait &&
			$stable(depth_ff) && pc_ff == $past(pc_seq))
		else $error("flow instruction acted in direct mode");

	a_wait_hold: assert property (@(posedge core_clk_in)
		disable iff (srst_in)
		in_wait && !wait_end |=> in_wait && $stable(pc_ff) && !done_ff)
		else $error("pc moved during pending wait");

	a_wait_entry: assert property (@(posedge core_clk_in)
		disable iff (srst_in)
		is_wait |=> in_wait && ticks_ff == $past(wait_amount) &&
			pc_ff == $past(pc_in))
		else $error("wait entry did not load counter");

	a_event_release: assert property (@(posedge core_clk_in)
		disable iff (srst_in)
		cond_done |=> done_ff && !in_wait &&
			flag_ff == $past(flag_ff && !clear_error_in))
		else $error("event did not end wait");

	a_timeout_set: assert property (@(posedge core_clk_in)
		disable iff (srst_in)
		tmo_expire |=> flag_ff && done_ff)
		else $error("timeout did not set flag");

	a_flag_sticky: assert property (@(posedge core_clk_in)
		disable iff (srst_in)
		flag_ff && !clear_error_in |=> flag_ff)
		else $error("timeout flag lost without clear");

	a_tick_count: assert property (@(posedge core_clk_in)
		disable iff (srst_in)
		in_wait && tick_pulse && !wait_end |=>
			ticks_ff == $past(ticks_ff) - 32'h0000_0001 &&
			presc_ff == 32'h0000_0000)
		else $error("tick count did not step");

	a_no_timeout: assert property (@(posedge core_clk_in)
		disable iff (srst_in)
		in_wait && is_event_type && !tmo_en_ff && !event_hit
			|=> in_wait && !done_ff)
		else $error("event wait ended without event");

	a_flag_cond: assert property (@(posedge core_clk_in)
		disable iff (srst_in)
		tmo_expire && cond_type_in == COND_TIMEOUT_ERROR
			|=> flag_cond_met_out || cond_type_in != COND_TIMEOUT_ERROR)
		else $error("condition 8 missed timeout flag");

	a_tick_hold: assert property (@(posedge core_clk_in)
		disable iff (srst_in)
		in_wait && wtype_ff == WAIT_TICKS && ticks_ff > 32'h0000_0001
			|=> in_wait && !done_ff)
		else $error("tick wait ended early");

	a_acc_source: assert property (@(posedge core_clk_in)
		disable iff (srst_in)
		is_wait && instr_in.value == TICKS_FROM_ACC
			|=> ticks_ff == $past(accumulator_in))
		else $error("wait did not take accumulator count");

	a_timeout_end: assert property (@(posedge core_clk_in)
		disable iff (srst_in)
		tmo_expire |=> !in_wait && pc_ff == $past(pc_ff) + PC_STEP)
		else $error("timeout did not resume program");

	a_home_release: assert property (@(posedge core_clk_in)
		disable iff (srst_in)
		in_wait && wtype_ff == HOME_SWITCH_WAIT && motor_ok &&
			motor_status_in.home_switch[midx] |=> done_ff && !in_wait)
		else $error("home switch did not end wait");

	a_end_release: assert property (@(posedge core_clk_in)
		disable iff (srst_in)
		in_wait && wtype_ff == END_SWITCH_WAIT && motor_ok &&
			motor_status_in.end_switch[midx] |=> done_ff && !in_wait)
		else $error("end switch did not end wait");

	a_homing_release: assert property (@(posedge core_clk_in)
		disable iff (srst_in)
		in_wait && wtype_ff == HOMING_DONE_WAIT && motor_ok &&
			motor_status_in.homing_done[midx] |=> done_ff && !in_wait)
		else $error("homing done did not end wait");

	a_flag_clear: assert property (@(posedge core_clk_in)
		disable iff (srst_in)
		clear_error_in && !tmo_expire |=> !flag_ff)
		else $error("clear did not drop timeout flag");

endmodule : program_flow_sequencer

// File: verif/prog_store.sv
`timescale 1ns/1ps
// Program memory model: instruction fetched at the presented address
module prog_store
	import flow_seq_pkg::*;
(
	input wire logic [31:0] addr_in,
	output flow_seq_pkg::instr_t data_out
);
	instr_t mem [0:255];
	// Combinational fetch, low address bits only
	assign data_out = mem[addr_in[7:0]];
endmodule : prog_store

// File: verif/tb_program_flow_sequencer.sv
`timescale 1ns/1ps
module tb_program_flow_sequencer;
	import flow_seq_pkg::*;
	logic core_clk_in = 0, srst_in = 1, standalone_in = 1;
	logic instr_valid_in = 0, clear_error_in = 0;
	logic [31:0] pc_in = 0, accumulator_in = 0, pc_out;
	logic [7:0] cond_type_in = 8'h08;
	instr_t instr_in;
	motor_status_t motor_status_in = '0;
	logic ready_out, done_out, waiting_out, timeout_error_flag_out;
	logic flag_cond_met_out;
	int err_total = 0, n_compared = 0, cyc;

	prog_store store (.addr_in(pc_in), .data_out(instr_in));
	program_flow_sequencer #(.TICK_CYCLES(4)) dut (
		.core_clk_in(core_clk_in), .srst_in(srst_in),
		.standalone_in(standalone_in), .instr_valid_in(instr_valid_in),
		.instr_in(instr_in), .pc_in(pc_in), .accumulator_in(accumulator_in),
		.motor_status_in(motor_status_in), .clear_error_in(clear_error_in),
		.cond_type_in(cond_type_in), .ready_out(ready_out),
		.done_out(done_out), .pc_out(pc_out), .waiting_out(waiting_out),
		.timeout_error_flag_out(timeout_error_flag_out),
		.flag_cond_met_out(flag_cond_met_out));

	// Clock, 20 ns period
	initial forever #10 core_clk_in = ~core_clk_in;

	// Compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_total++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// Verdict and end of run
	task automatic close_out;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : close_out

	// One instruction from memory; other events at 10, ev at 20
	task automatic run(input logic [7:0] op, ty, mo,
		input logic [31:0] v, a, input motor_status_t ev);
		@(posedge core_clk_in);
		store.mem[a[7:0]] <= '{op, ty, mo, v};
		pc_in <= a;
		instr_valid_in <= 1'b1;
		motor_status_in <= '0;
		@(posedge core_clk_in);
		instr_valid_in <= 1'b0;
		cyc = 0;
		#1;
		check(32'(waiting_out), 32'(op == OP_WAIT && standalone_in));
		while (done_out !== 1'b1)
		begin
			if (waiting_out === 1'b1) check(pc_out, a);
			if (waiting_out === 1'b1) check(32'(ready_out), 32'h0);
			@(posedge core_clk_in);
			cyc++;
			if (cyc == 10) motor_status_in <= ~ev;
			if (cyc == 20) motor_status_in <= ev;
			#1;
			if (cyc > 400)
			begin
				err_total++;
				close_out();
			end
		end
	endtask : run

	// Jump, and jump ignored in direct mode
	task automatic t_jump;
		run(OP_JUMP_ALWAYS, 8'h05, 8'h02, 32'h0000_000A, 32'h0000_0003, '0);
		check(pc_out, 32'h0000_000A);
		@(posedge core_clk_in);
		standalone_in <= 1'b0;
		#1;
		check(32'(done_out), 32'h0);
		run(OP_JUMP_ALWAYS, 8'h00, 8'h00, 32'h0000_000A, 32'h0000_0005, '0);
		check(pc_out, 32'h0000_0006);
		run(OP_WAIT, WAIT_TICKS, 8'h00, 32'h0000_0003, 32'h0000_0007, '0);
		check(32'(cyc), 32'h0);
		check(pc_out, 32'h0000_0008);
		@(posedge core_clk_in);
		standalone_in <= 1'b1;
		$display("test jump done");
	endtask : t_jump

	// Nine calls then nine returns: overflow and underflow ignored
	task automatic t_stack;
		for (int i = 0; i < 9; i++)
		begin
			run(OP_CALL_SUBROUTINE, 8'h00, 8'h00, 32'h100 + 32'(i),
				32'h40 + 32'(i), '0);
			check(pc_out, i < 8 ? 32'h100 + 32'(i) : 32'h49);
		end
		for (int i = 0; i < 9; i++)
		begin
			run(OP_RETURN_SUBROUTINE, 8'h00, 8'h00, 32'h0, 32'h80 + 32'(i), '0);
			check(pc_out, i < 8 ? 32'h48 - 32'(i) : 32'h89);
		end
		$display("test stack done");
	endtask : t_stack

	// Tick waits, direct count and accumulator count
	task automatic t_ticks;
		run(OP_WAIT, WAIT_TICKS, 8'h07, 32'h0000_0003, 32'h0000_0010, '0);
		check(32'(cyc inside {[11:14]}), 32'h1);
		check(pc_out, 32'h0000_0011);
		@(posedge core_clk_in);
		accumulator_in <= 32'h0000_0003;
		run(OP_WAIT, WAIT_TICKS, 8'h00, TICKS_FROM_ACC, 32'h0000_0012, '0);
		check(32'(cyc inside {[11:14]}), 32'h1);
		$display("test ticks done");
	endtask : t_ticks

	// Four event kinds on motor 1, no timeout, event late
	task automatic t_events;
		motor_status_t e;
		for (int k = 1; k < 5; k++)
		begin
			e = motor_status_t'(12'h001 << (1 + 3 * (4 - k)));
			run(OP_WAIT, 8'(k), 8'h01, 32'h0, 32'h20 + 32'(k), e);
			check(32'(cyc > 20), 32'h1);
			check(32'(timeout_error_flag_out), 32'h0);
		end
		$display("test events done");
	endtask : t_events

	// Timeout sets flag, condition 8 sees it, clear drops it
	task automatic t_timeout;
		run(OP_WAIT, WAIT_TARGET_REACHED, 8'h02, 32'h2, 32'h30, '0);
		check(32'(cyc inside {[7:10]}), 32'h1);
		check(32'(timeout_error_flag_out), 32'h1);
		check(32'(flag_cond_met_out), 32'h1);
		check(pc_out, 32'h0000_0031);
		@(posedge core_clk_in);
		cond_type_in <= 8'h07;
		#1;
		check(32'(flag_cond_met_out), 32'h0);
		@(posedge core_clk_in);
		clear_error_in <= 1'b1;
		cond_type_in <= 8'h08;
		@(posedge core_clk_in);
		clear_error_in <= 1'b0;
		#1;
		check(32'(timeout_error_flag_out), 32'h0);
		$display("test timeout done");
	endtask : t_timeout

	// Reset mid run empties the stack
	task automatic t_reset;
		run(OP_CALL_SUBROUTINE, 8'h00, 8'h00, 32'h0000_0090, 32'h0000_0050, '0);
		@(posedge core_clk_in);
		srst_in <= 1'b1;
		@(posedge core_clk_in);
		srst_in <= 1'b0;
		#1;
		check(pc_out, PC_RESET);
		check(32'(ready_out), 32'h1);
		run(OP_RETURN_SUBROUTINE, 8'h00, 8'h00, 32'h0, 32'h0000_0060, '0);
		check(pc_out, 32'h0000_0061);
		$display("test reset done");
	endtask : t_reset

	// Main sequence
	initial
	begin
		repeat (8) @(posedge core_clk_in);
		srst_in <= 1'b0;
		t_jump();
		t_stack();
		t_ticks();
		t_events();
		t_timeout();
		t_reset();
		close_out();
	end
endmodule : tb_program_flow_sequencer
